/* src/msp_defs.svh */
// Purpose: Offsets, field positions, reset values and map constants of the register set
// Assumes: Byte addresses on the Avalon-MM slave, one 32-bit word per register
// Notes:   Internal addresses are the values software loads into the address holder
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH

// ------------------------------------------------------------------
// Avalon byte offsets
// ------------------------------------------------------------------
`define MSP_OFS_LSR_LAST 9'h03C
`define MSP_OFS_HOLDER 9'h040
`define MSP_OFS_SAVE_HIGH 9'h044
`define MSP_OFS_TAGS 9'h048
`define MSP_OFS_STATUS 9'h04C
`define MSP_OFS_PORT 9'h050

// ------------------------------------------------------------------
// Local register file entries
// ------------------------------------------------------------------
`define MSP_LSR_OP1 4'h0
`define MSP_LSR_OP2 4'h1
`define MSP_LSR_IAR 4'h2
`define MSP_LSR_OPBYTE 4'h3
`define MSP_LSR_QBYTE 4'h4
`define MSP_LSR_IDX1 4'h5
`define MSP_LSR_IDX2 4'h6
`define MSP_LSR_RECALL 4'h7
`define MSP_LSR_LENREC 4'h8
`define MSP_LSR_WORK4 4'h9
`define MSP_LSR_XSAVE 4'hD
`define MSP_LSR_RSAVE 4'hE

// ------------------------------------------------------------------
// Internal (system) addresses of the translation groups
// ------------------------------------------------------------------
`define MSP_IA_XLAT_FIRST 16'h0080
`define MSP_IA_XLAT_LAST 16'h017F
`define MSP_IA_TASK1 9'h080
`define MSP_IA_REAL 9'h0A0
`define MSP_IA_IO1 9'h0A8
`define MSP_IA_TASK0 9'h0C0
`define MSP_IA_IO0 9'h0E0
`define MSP_IA_IO2 9'h100
`define MSP_IO1_PAGES 5'd24

// ------------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------------
`define MSP_PAGE_LSB 11
`define MSP_REAL_LSB 13
`define MSP_PROTECT 16'hFFFF
`define MSP_RST_WORD 16'h0000
`define MSP_TAGH_MSB 10
`define MSP_TAGH_LSB 8
`define MSP_TAGL_MSB 7
`define MSP_TAGL_LSB 2
`define MSP_ST_ERR 0
`define MSP_ST_BUSY 1
`define MSP_ST_TAGV 2
`define MSP_ST_HIT 3

`endif

/* src/msp_pkg.sv */
// Purpose: Types of the main processor register set
// Assumes: Constants come from msp_defs.svh
// Notes:   State of the top module is one packed struct
package msp_pkg;

    typedef enum logic [2:0] {
        MSP_S_IDLE = 3'b001,
        MSP_S_XLAT = 3'b010,
        MSP_S_WAIT = 3'b100
    } msp_state_t;

    typedef enum logic [2:0] {
        MSP_G_TASK0 = 3'h0,
        MSP_G_TASK1 = 3'h1,
        MSP_G_IO0 = 3'h2,
        MSP_G_IO1 = 3'h3,
        MSP_G_IO2 = 3'h4,
        MSP_G_IO3 = 3'h5,
        MSP_G_IO4 = 3'h6,
        MSP_G_IO5 = 3'h7
    } msp_grp_t;

    typedef struct packed {
        logic req;
        logic real_m;
        msp_grp_t grp;
        logic [15:0] addr;
    } msp_acc_t;

    typedef struct packed {
        msp_state_t st;
        logic [15:0][15:0] local_register_file;
        logic [255:0][15:0] xlat;
        logic [15:0] holder;
        msp_grp_t grp;
        logic real_m;
        logic [7:0] xs_hi;
        logic [7:0] rs_hi;
        logic [2:0] tag_hi;
        logic [5:0] tag_lo;
        logic tag_vld;
        logic err;
        logic [23:0] phys;
        logic start;
        logic block;
        logic hit;
        logic wreq;
        logic [31:0] rdata;
        logic [15:0] lsr_rd;
    } msp_regs_t;

endpackage

/* src/msp_regs.sv */
// Purpose: Local registers, translation registers, address holder and buffer tags
// Assumes: All inputs except the Avalon bus come from logic on CLK_I
// Notes:   Avalon answers one cycle after a request; writes land on the accept edge
`timescale 1ns/1ps
`include "msp_defs.svh"

module msp_regs import msp_pkg::*; #(
    parameter int XLAT_COUNT = 256
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Avalon-MM slave
    input wire logic [8:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // Datapath local register port
    input wire logic LSR_WE_I,
    input wire logic [3:0] LSR_SEL_I,
    input wire logic [15:0] LSR_WDATA_I,
    output logic [15:0] LSR_RDATA_O,
    // Instruction capture
    input wire logic INSN_START_I,
    input wire logic [7:0] OPBYTE_I,
    input wire logic [7:0] QBYTE_I,
    input wire logic INSN_FAIL_I,
    input wire logic [7:0] RBYTE_I,
    // Storage access
    input wire msp_acc_t ACC_I,
    input wire logic STG_DONE_I,
    input wire logic BUF_FILL_I,
    output logic ACC_IDLE_O,
    output logic [23:0] STG_ADDR_O,
    output logic STG_START_O,
    output logic STG_BLOCK_O,
    output logic STG_HIT_O,
    output logic ERR_O,
    // Save area addresses
    output logic [23:0] XSAVE_ADDR_O,
    output logic [23:0] RSAVE_ADDR_O
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (XLAT_COUNT != 256) begin : g_bad_count
        $error("XLAT_COUNT must be 256: 248 translation plus 8 real-mapping");
    end

    msp_regs_t r;
    msp_regs_t n;

    logic bus_req;
    logic commit;
    logic [3:0] word;
    logic [15:0] wd16;
    logic [31:0] rmux;
    logic in_lsr;
    logic in_x;
    logic [7:0] port_x;
    logic [15:0] port_val;
    logic [4:0] page;
    logic [8:0] base;
    logic [8:0] sys;
    logic [7:0] xidx;
    logic [15:0] xval;
    logic blk;
    logic [23:0] phys_n;
    logic match;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] be);
        merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.start = 1'b0;
        n.block = 1'b0;
        word = AVS_ADDRESS_I[5:2];
        bus_req = AVS_READ_I | AVS_WRITE_I;
        commit = AVS_WRITE_I & ~r.wreq;
        wd16 = 16'h0000;
        rmux = 32'h0000_0000;
        port_val = 16'h0000;

        // Internal address decode for the sense/load port
        in_lsr = (r.holder[15:4] == 12'h000);
        in_x = (r.holder >= `MSP_IA_XLAT_FIRST) && (r.holder <= `MSP_IA_XLAT_LAST);
        port_x = 8'(r.holder - `MSP_IA_XLAT_FIRST);
        if (in_lsr) begin
            port_val = r.local_register_file[r.holder[3:0]];
        end else if (in_x) begin
            port_val = r.xlat[port_x];
        end

        // Translation lookup for the access in flight
        page = r.holder[15:`MSP_PAGE_LSB];
        unique case (r.grp)
            MSP_G_TASK1: base = `MSP_IA_TASK1;
            MSP_G_TASK0: base = `MSP_IA_TASK0;
            MSP_G_IO1: base = `MSP_IA_IO1;
            MSP_G_IO0: base = `MSP_IA_IO0;
            default: base = 9'(`MSP_IA_IO2 + {r.grp - MSP_G_IO2, 5'h00});
        endcase
        if (r.real_m) begin
            sys = `MSP_IA_REAL + {6'h00, r.holder[15:`MSP_REAL_LSB]};
        end else begin
            sys = 9'(base + {4'h0, page});
        end
        xidx = 8'(sys - `MSP_IA_TASK1);
        xval = r.xlat[xidx];
        // IO group 1 has only 24 pages; a page past it is treated as protected
        blk = (xval == `MSP_PROTECT) ||
              (!r.real_m && r.grp == MSP_G_IO1 && page >= `MSP_IO1_PAGES);
        if (r.real_m) begin
            phys_n = {xval[10:0], r.holder[`MSP_REAL_LSB-1:0]};
        end else begin
            phys_n = {xval[12:0], r.holder[`MSP_PAGE_LSB-1:0]};
        end
        match = r.tag_vld && phys_n[`MSP_TAGH_MSB:`MSP_TAGH_LSB] == r.tag_hi &&
                phys_n[`MSP_TAGL_MSB:`MSP_TAGL_LSB] == r.tag_lo;

        // Avalon read mux, captured one cycle before the accept edge
        if (AVS_ADDRESS_I <= `MSP_OFS_LSR_LAST) begin
            rmux = {16'h0000, r.local_register_file[word]};
        end else begin
            unique case (AVS_ADDRESS_I)
                `MSP_OFS_HOLDER: rmux = 32'h0000_0000;
                `MSP_OFS_SAVE_HIGH: rmux = {16'h0000, r.rs_hi, r.xs_hi};
                `MSP_OFS_TAGS: rmux = {23'h000000, r.tag_lo, r.tag_hi};
                `MSP_OFS_STATUS: rmux = {28'h0000000, r.hit, r.tag_vld,
                                         ~r.st[0], r.err};
                `MSP_OFS_PORT: rmux = {16'h0000, port_val};
                default: rmux = 32'h0000_0000;
            endcase
        end
        n.wreq = ~(bus_req & r.wreq);
        if (bus_req && r.wreq) begin
            n.rdata = rmux;
        end

        // Bus writes on the accept edge
        if (commit) begin
            if (AVS_ADDRESS_I <= `MSP_OFS_LSR_LAST) begin
                n.local_register_file[word] = merge16(r.local_register_file[word], AVS_WRITEDATA_I[15:0],
                                      AVS_BYTEENABLE_I[1:0]);
                if (word == `MSP_LSR_LENREC) begin
                    n.local_register_file[word][15:8] = 8'h00;
                end
            end else begin
                unique case (AVS_ADDRESS_I)
                    `MSP_OFS_HOLDER: begin
                        if (r.st == MSP_S_IDLE && !ACC_I.req) begin
                            n.holder = merge16(r.holder, AVS_WRITEDATA_I[15:0],
                                               AVS_BYTEENABLE_I[1:0]);
                        end
                    end
                    `MSP_OFS_SAVE_HIGH: begin
                        if (AVS_BYTEENABLE_I[0]) n.xs_hi = AVS_WRITEDATA_I[7:0];
                        if (AVS_BYTEENABLE_I[1]) n.rs_hi = AVS_WRITEDATA_I[15:8];
                    end
                    `MSP_OFS_TAGS: begin
                        if (AVS_BYTEENABLE_I[0]) n.tag_hi = AVS_WRITEDATA_I[2:0];
                        if (AVS_BYTEENABLE_I[1:0] == 2'b11) n.tag_lo = AVS_WRITEDATA_I[8:3];
                    end
                    `MSP_OFS_STATUS: begin
                        if (AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[`MSP_ST_ERR]) n.err = 1'b0;
                    end
                    `MSP_OFS_PORT: begin
                        wd16 = merge16(port_val, AVS_WRITEDATA_I[15:0], AVS_BYTEENABLE_I[1:0]);
                        if (in_lsr) n.local_register_file[r.holder[3:0]] = wd16;
                        else if (in_x) n.xlat[port_x] = wd16;
                    end
                    default: ;
                endcase
            end
        end

        // Datapath writes override the bus; instruction capture overrides both
        if (LSR_WE_I) begin
            n.local_register_file[LSR_SEL_I] = LSR_WDATA_I;
        end
        if (INSN_START_I) begin
            n.local_register_file[`MSP_LSR_OPBYTE] = {8'h00, OPBYTE_I};
            n.local_register_file[`MSP_LSR_QBYTE] = {8'h00, QBYTE_I};
        end
        if (INSN_FAIL_I) begin
            n.local_register_file[`MSP_LSR_LENREC] = {8'h00, RBYTE_I};
        end
        n.lsr_rd = r.local_register_file[LSR_SEL_I];

        // Access sequencer
        unique case (r.st)
            MSP_S_IDLE: begin
                if (ACC_I.req) begin
                    n.holder = ACC_I.addr;
                    n.grp = ACC_I.grp;
                    n.real_m = ACC_I.real_m;
                    n.st = MSP_S_XLAT;
                end
            end
            MSP_S_XLAT: begin
                if (blk) begin
                    n.block = 1'b1;
                    n.err = 1'b1;
                    n.st = MSP_S_IDLE;
                end else begin
                    n.phys = phys_n;
                    n.hit = match;
                    n.start = 1'b1;
                    n.st = MSP_S_WAIT;
                end
            end
            MSP_S_WAIT: begin
                if (STG_DONE_I) n.st = MSP_S_IDLE;
            end
            default: n.st = MSP_S_IDLE;
        endcase

        // Buffer tags follow the block just loaded
        if (BUF_FILL_I) begin
            n.tag_hi = r.phys[`MSP_TAGH_MSB:`MSP_TAGH_LSB];
            n.tag_lo = r.phys[`MSP_TAGL_MSB:`MSP_TAGL_LSB];
            n.tag_vld = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r <= '0;
            r.st <= MSP_S_IDLE;
            r.grp <= MSP_G_TASK0;
            r.wreq <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign AVS_READDATA_O = r.rdata;
    assign AVS_WAITREQUEST_O = r.wreq;
    assign LSR_RDATA_O = r.lsr_rd;
    assign ACC_IDLE_O = r.st[0];
    assign STG_ADDR_O = r.phys;
    assign STG_START_O = r.start;
    assign STG_BLOCK_O = r.block;
    assign STG_HIT_O = r.hit;
    assign ERR_O = r.err;
    assign XSAVE_ADDR_O = {r.xs_hi, r.local_register_file[`MSP_LSR_XSAVE]};
    assign RSAVE_ADDR_O = {r.rs_hi, r.local_register_file[`MSP_LSR_RSAVE]};

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_protect_blocks: assert property (
        (r.st == MSP_S_XLAT && blk) |=> STG_BLOCK_O && !STG_START_O && ACC_IDLE_O)
        else $error("protected access was not blocked");
    a_block_sets_err: assert property (STG_BLOCK_O |-> ERR_O ##1 ERR_O)
        else $error("blocked access left no error flag");
    a_holder_frozen: assert property (
        (r.st == MSP_S_WAIT) |=> r.holder == $past(r.holder))
        else $error("address holder changed during access");
    a_access_start: assert property (
        (r.st == MSP_S_IDLE && ACC_I.req) |-> ##2 (STG_START_O || STG_BLOCK_O))
        else $error("access did not start two cycles after request");
    a_insn_copy: assert property (
        (INSN_START_I && !LSR_WE_I) |=>
        r.local_register_file[`MSP_LSR_OPBYTE] == {8'h00, $past(OPBYTE_I)} &&
        r.local_register_file[`MSP_LSR_QBYTE] == {8'h00, $past(QBYTE_I)})
        else $error("instruction bytes not saved");
    a_len_recall: assert property (
        (INSN_FAIL_I && !(LSR_WE_I && LSR_SEL_I == `MSP_LSR_LENREC)) |=>
        r.local_register_file[`MSP_LSR_LENREC] == {8'h00, $past(RBYTE_I)})
        else $error("length recall not captured");
    a_tag_load: assert property (
        BUF_FILL_I |=> r.tag_vld && r.tag_hi == $past(r.phys[10:8]) &&
        r.tag_lo == $past(r.phys[7:2]))
        else $error("buffer tags not loaded with the fill");
    a_hit_match: assert property (
        (STG_START_O && !$past(BUF_FILL_I)) |->
        STG_HIT_O == (r.tag_vld && STG_ADDR_O[10:8] == r.tag_hi && STG_ADDR_O[7:2] == r.tag_lo))
        else $error("buffer hit does not match the tags");
    a_holder_hidden: assert property (
        (AVS_READ_I && AVS_WAITREQUEST_O && AVS_ADDRESS_I == `MSP_OFS_HOLDER) |=>
        !AVS_WAITREQUEST_O && AVS_READDATA_O == 32'h0000_0000)
        else $error("address holder contents were sensed");
    a_bus_answer: assert property (
        (bus_req && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
        else $error("bus answer not one cycle long");

    c_blocked: cover property (STG_BLOCK_O);
    c_hit: cover property (STG_START_O && STG_HIT_O);
    c_port_read: cover property (AVS_READ_I && !AVS_WAITREQUEST_O &&
                                 AVS_ADDRESS_I == `MSP_OFS_PORT);
    c_tag_fill: cover property (BUF_FILL_I ##1 ACC_I.req);

endmodule

/* verif/msp_stg_model.sv */
// Purpose: Storage side model that ends storage cycles and reports buffer loads
// Assumes: One clock shared with the register set
// Notes:   Latency and buffer fill are set by the bench per access
`timescale 1ns/1ps
module msp_stg_model (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Control from the bench
    input wire logic [3:0] LAT_I,
    input wire logic FILL_I,
    // Storage cycle handshake
    input wire logic STG_START_I,
    output logic STG_DONE_O,
    output logic BUF_FILL_O
);
    logic [3:0] cnt_r;
    logic busy_r;

    // ------------------------------------------------------------------
    // Cycle end LAT_I+1 cycles after the start is taken, buffer load completes with it
    // ------------------------------------------------------------------
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cnt_r <= 4'h0;
            busy_r <= 1'b0;
            STG_DONE_O <= 1'b0;
            BUF_FILL_O <= 1'b0;
        end else begin
            STG_DONE_O <= 1'b0;
            BUF_FILL_O <= 1'b0;
            if (STG_START_I) begin
                busy_r <= 1'b1;
                cnt_r <= LAT_I;
            end else if (busy_r) begin
                if (cnt_r == 4'h0) begin
                    busy_r <= 1'b0;
                    STG_DONE_O <= 1'b1;
                    BUF_FILL_O <= FILL_I;
                end else begin
                    cnt_r <= cnt_r - 4'h1;
                end
            end
        end
    end
endmodule

/* verif/msp_regs_test.sv */
// Purpose: Self-checking bench for the main processor register set
// Assumes: Avalon answers within a few cycles; storage side is msp_stg_model
// Notes:   All stimulus by non-blocking assignment right after the rising edge
`timescale 1ns/1ps
module msp_regs_test import msp_pkg::*; ;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] av_addr = 9'h000;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [31:0] av_rdata;
    logic av_wait;
    logic lsr_we = 1'b0;
    logic [3:0] lsr_sel = 4'h0;
    logic [15:0] lsr_wdata = 16'h0;
    logic [15:0] lsr_rdata;
    logic insn_start = 1'b0;
    logic insn_fail = 1'b0;
    logic [7:0] op_b = 8'h0;
    logic [7:0] q_b = 8'h0;
    logic [7:0] r_b = 8'h0;
    msp_acc_t acc = '0;
    logic stg_done, buf_fill, acc_idle, stg_start, stg_block, stg_hit, err;
    logic [23:0] stg_addr, xsave, rsave, phys;
    logic [3:0] lat = 4'h1;
    logic fill = 1'b0;
    logic hit, blk;
    logic [31:0] q;
    int num_errors = 0;
    int tests_run = 0;

    always #2.5 clk = ~clk;

    msp_regs dut_u (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(av_addr),
        .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr), .AVS_WRITEDATA_I(av_wdata),
        .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(av_rdata), .AVS_WAITREQUEST_O(av_wait),
        .LSR_WE_I(lsr_we), .LSR_SEL_I(lsr_sel), .LSR_WDATA_I(lsr_wdata),
        .LSR_RDATA_O(lsr_rdata), .INSN_START_I(insn_start), .OPBYTE_I(op_b), .QBYTE_I(q_b),
        .INSN_FAIL_I(insn_fail), .RBYTE_I(r_b), .ACC_I(acc), .STG_DONE_I(stg_done),
        .BUF_FILL_I(buf_fill), .ACC_IDLE_O(acc_idle), .STG_ADDR_O(stg_addr),
        .STG_START_O(stg_start), .STG_BLOCK_O(stg_block), .STG_HIT_O(stg_hit),
        .ERR_O(err), .XSAVE_ADDR_O(xsave), .RSAVE_ADDR_O(rsave));

    msp_stg_model stg_u (.CLK_I(clk), .RST_N_I(rst_n), .LAT_I(lat), .FILL_I(fill),
        .STG_START_I(stg_start), .STG_DONE_O(stg_done), .BUF_FILL_O(buf_fill));

    // ------------------------------------------------------------------
    // Comparison, bus and access tasks
    // ------------------------------------------------------------------
    task final_report();
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        av_addr <= a;
        av_wdata <= d;
        av_rd <= !w;
        av_wr <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 50);
        q = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        if (av_wait !== 1'b0) begin
            num_errors++;
            final_report();
        end
    endtask

    task wr(input logic [8:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input logic [8:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task idle_wait();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (acc_idle !== 1'b1 && n < 100);
        if (acc_idle !== 1'b1) begin
            num_errors++;
            final_report();
        end
    endtask

    task access(input logic rm, input logic [2:0] g, input logic [15:0] a, input logic wi);
        int n;
        idle_wait();
        acc <= '{req: 1'b1, real_m: rm, grp: msp_grp_t'(g), addr: a};
        @(posedge clk);
        acc.req <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (stg_start !== 1'b1 && stg_block !== 1'b1 && n < 20);
        if (stg_start !== 1'b1 && stg_block !== 1'b1) begin
            num_errors++;
            final_report();
        end
        phys = stg_addr;
        hit = stg_hit;
        blk = stg_block;
        if (wi) begin
            idle_wait();
        end
    endtask

    task done_test(input string s);
        $display("test %s done, errors so far %0d", s, num_errors);
    endtask

    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        int i;
        logic [31:0] e;
        logic [23:0] p1;
        logic [15:0] gb [8];
        gb = '{16'h00C0, 16'h0080, 16'h00E0, 16'h00A8, 16'h0100, 16'h0120, 16'h0140, 16'h0160};
        repeat (4) @(posedge clk);
        chk({31'h0, av_wait}, 32'h1);
        chk({31'h0, acc_idle}, 32'h1);
        rst_n <= 1'b1;
        for (i = 0; i < 16; i++) wr(9'(i * 4), {16'hFFFF, 16'hA500 + 16'(i)});
        for (i = 0; i < 16; i++) begin
            e = {16'h0, 16'hA500 + 16'(i)};
            if (i == 8) e[15:8] = 8'h00;
            rd(9'(i * 4), e);
        end
        wr(9'h040, 32'h0003);
        rd(9'h040, 32'h0);
        rd(9'h07C, 32'h0);
        done_test("local");
        @(posedge clk);
        lsr_we <= 1'b1;
        lsr_sel <= 4'h9;
        lsr_wdata <= 16'hBEEF;
        insn_start <= 1'b1;
        op_b <= 8'h5A;
        q_b <= 8'hC3;
        insn_fail <= 1'b1;
        r_b <= 8'h7E;
        @(posedge clk);
        lsr_we <= 1'b0;
        insn_start <= 1'b0;
        insn_fail <= 1'b0;
        repeat (2) @(posedge clk);
        chk({16'h0, lsr_rdata}, 32'hBEEF);
        rd(9'h00C, 32'h5A);
        rd(9'h010, 32'hC3);
        rd(9'h020, 32'h7E);
        wr(9'h034, 32'h1234);
        wr(9'h038, 32'h5678);
        wr(9'h044, 32'hBBAA);
        @(posedge clk);
        chk({8'h0, xsave}, 32'hAA1234);
        chk({8'h0, rsave}, 32'hBB5678);
        done_test("capture");
        for (i = 0; i < 8; i++) begin
            wr(9'h040, {16'h0, gb[i] + 16'h1});
            wr(9'h050, {16'h0, 16'h0010 + 16'(i)});
            access(1'b0, 3'(i), 16'h08A4, 1'b1);
            chk({8'h0, phys}, {8'h0, 13'h0010 + 13'(i), 11'h0A4});
        end
        for (i = 0; i < 8; i++) begin
            wr(9'h040, {16'h0, 16'h00A0 + 16'(i)});
            wr(9'h050, {16'h0, 16'h0200 + 16'(i)});
            access(1'b1, 3'h0, {3'(i), 13'h0123}, 1'b1);
            chk({8'h0, phys}, {8'h0, 11'h200 + 11'(i), 13'h0123});
        end
        wr(9'h040, 32'h00A7);
        rd(9'h050, 32'h0207);
        done_test("translation");
        fill <= 1'b1;
        access(1'b0, 3'h1, 16'h08A4, 1'b1);
        fill <= 1'b0;
        p1 = phys;
        chk({8'h0, p1}, 32'h0000_88A4);
        rd(9'h048, 32'h0000_0148);
        access(1'b0, 3'h1, 16'h08A4, 1'b1);
        chk({31'h0, hit}, 32'h1);
        access(1'b0, 3'h1, 16'h09A4, 1'b1);
        chk({31'h0, hit}, 32'h0);
        access(1'b0, 3'h1, 16'h08A0, 1'b1);
        chk({31'h0, hit}, 32'h0);
        access(1'b0, 3'h1, 16'h08A5, 1'b1);
        chk({31'h0, hit}, 32'h1);
        done_test("buffer");
        wr(9'h040, 32'h0082);
        wr(9'h050, 32'hFFFF);
        access(1'b0, 3'h1, 16'h1000, 1'b1);
        chk({31'h0, blk}, 32'h1);
        chk({31'h0, err}, 32'h1);
        bus(1'b0, 9'h04C, 32'h0);
        chk({31'h0, q[0]}, 32'h1);
        wr(9'h04C, 32'h1);
        @(posedge clk);
        chk({31'h0, err}, 32'h0);
        done_test("protect");
        wr(9'h040, 32'h0005);
        lat <= 4'hA;
        access(1'b0, 3'h0, 16'h0005, 1'b0);
        wr(9'h040, 32'h0006);
        idle_wait();
        lat <= 4'h1;
        wr(9'h050, 32'h7777);
        rd(9'h014, 32'h7777);
        rd(9'h018, 32'hA506);
        done_test("holder");
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk({8'h0, xsave}, 32'h0);
        chk({31'h0, err}, 32'h0);
        chk({31'h0, av_wait}, 32'h1);
        rst_n <= 1'b1;
        rd(9'h014, 32'h0);
        done_test("reset");
        final_report();
    end
endmodule
